// file: core/fpm_pkg.sv
// Package of constants and types for the front panel menu controller.
package fpm_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CH        = 16;       // Channels in the rack.
  localparam int unsigned MENU_ROWS     = 5;        // Option rows in the main menu.
  localparam int unsigned CLK_HZ        = 40000000; // System clock rate.
  localparam int unsigned DEBOUNCE_MS   = 10;       // Button must stay steady this long.
  localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned FLASH_MS      = 250;      // Half period of one lamp flash.
  localparam int unsigned FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned FLASH_COUNT   = 3;        // Number of lamp flashes.

  // ---------------------------------------------------------------
  // Gain codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] GAIN_X1     = 2'h0;  // Unity gain code.
  localparam logic [1:0] GAIN_X10    = 2'h1;  // Gain of ten.
  localparam logic [1:0] GAIN_X100   = 2'h2;  // Gain of one hundred.
  localparam logic [4:0] SW_NONE     = 5'h00; // No channel routed to a switcher.
  localparam logic [3:0] OVLD_RST_V  = 4'hA;  // Overload threshold in volts.
  localparam logic [4:0] RACK_RST    = 5'h01; // Rack number shown in submenus.

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // Menu screen in use.
  typedef enum logic [2:0] {
    FPM_SCR_INIT,
    FPM_SCR_MAIN,
    FPM_SCR_GAIN,
    FPM_SCR_MUX,
    FPM_SCR_STAT,
    FPM_SCR_LEDS
  } fpm_screen_e;

  // Debounced press pulses from the five buttons.
  typedef struct packed {
    logic up;
    logic down;
    logic side;
    logic enter_exit;
    logic reset_btn;
  } fpm_keys_s;

  // What the display logic must render.
  typedef struct packed {
    logic [2:0] screen;    // fpm_screen_e code.
    logic [2:0] top_row;   // Main menu row shown on the top line.
    logic [2:0] cur_row;   // Row holding the cursor.
    logic [1:0] cur_col;   // Option column holding the cursor.
    logic [4:0] rack_number_field;
    logic [4:0] channel;   // Channel shown, 1 to 16.
    logic [1:0] gain;      // Gain code of that channel.
    logic       sub_field; // Submenu field under the cursor.
    logic [4:0] switcher_one_channel;
    logic [4:0] switcher_two_channel;
    logic       fault_flag;
    logic       ovld_flag;
    logic       test_on;   // Lamp test shown as on.
  } fpm_disp_s;

  // Number of options on each main menu row.
  function automatic logic [1:0] fpm_row_len(input logic [2:0] row);
    fpm_row_len = (row == 3'h4) ? 2'h3 : 2'h3;
  endfunction : fpm_row_len

endpackage : fpm_pkg

// file: core/fpm_debounce.sv
// Push button debouncer with a single press pulse per press.
`timescale 1ns/1ps
`default_nettype none
module fpm_debounce #(
  parameter int unsigned N   = 5,
  parameter int unsigned CYC = fpm_pkg::DEBOUNCE_CYC
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [N-1:0] btn_raw,   // Raw levels, high while pressed.
  output logic      [N-1:0] press      // One-cycle press pulses.
);
  import fpm_pkg::*;

  // The steady-time counter is 24 bits wide, so longer settle times are refused.
  if (N < 1 || CYC < 2 || CYC > 32'h0100_0000) begin : g_bad_par
    $error("fpm_debounce: bad parameters");
  end

  logic [N-1:0]      stable_q;          // Accepted button levels.
  logic [N-1:0][23:0] cnt_q;            // Steady-time counters.

  // ---------------------------------------------------------------
  // Debounce counters
  // ---------------------------------------------------------------
  // A level must differ from the accepted one for CYC cycles before it is taken.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stable_q <= '0;
      cnt_q    <= '0;
      press    <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        press[i] <= 1'b0;
        if (btn_raw[i] == stable_q[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] == 24'(CYC - 1)) begin
          cnt_q[i]    <= '0;
          stable_q[i] <= btn_raw[i];
          press[i]    <= btn_raw[i];        // Rising edge only.
        end else begin
          cnt_q[i] <= cnt_q[i] + 24'h000001;
        end
      end
    end
  end
endmodule : fpm_debounce
`default_nettype wire

// file: core/fpm_menu.sv
// Front panel menu controller top module.
`timescale 1ns/1ps
`default_nettype none
module fpm_menu #(
  parameter int unsigned DEBOUNCE = fpm_pkg::DEBOUNCE_CYC, // Settle time in cycles.
  parameter int unsigned FLASH    = fpm_pkg::FLASH_CYC     // Lamp half period in cycles.
) (
  input  wire logic                             clk_sys,
  input  wire logic                             nrst,
  input  wire logic                             btn_up,
  input  wire logic                             btn_down,
  input  wire logic                             btn_side,
  input  wire logic                             btn_enter_exit,
  input  wire logic                             btn_reset,
  input  wire logic [fpm_pkg::NUM_CH-1:0]       fault_in,
  input  wire logic [fpm_pkg::NUM_CH-1:0]       ovld_in,
  output fpm_pkg::fpm_disp_s                    disp,
  output logic [2*fpm_pkg::NUM_CH-1:0]          gain_sel,
  output logic [4:0]                            switcher_one_channel,
  output logic [4:0]                            switcher_two_channel,
  output logic                                  autorange_en,
  output logic                                  cal_en,
  output logic                                  integ_en,
  output logic                                  filter_en,
  output logic [3:0]                            ovld_thresh_v,
  output logic                                  reset_lamp,
  output logic                                  panel_lamps_on
);
  import fpm_pkg::*;

  // Both timers need at least two cycles to tell start from end.
  if (DEBOUNCE < 2 || FLASH < 2) begin : g_bad_par
    $error("fpm_menu: bad timing parameters");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  fpm_keys_s           key;             // Press pulses.
  logic [4:0]          key_vec;         // Pulses as a vector.
  fpm_screen_e         scr_q;           // Current screen.
  logic [2:0]          top_q;           // Top visible menu row.
  logic [2:0]          row_q;           // Cursor row.
  logic [1:0]          col_q;           // Cursor column.
  logic                fld_q;           // Submenu field select.
  logic [3:0]          ch_q;            // Channel index 0..15.
  logic [1:0]          gain_q [NUM_CH]; // Per-channel gain codes.
  logic [4:0]          sw1_q;           // Switcher one channel.
  logic [4:0]          sw2_q;           // Switcher two channel.
  logic [NUM_CH-1:0]   ovl_latch_q;     // Latched overloads.
  logic                flashing_q;      // Lamp flash sequence running.
  logic                from_reset_q;    // Flash started by a reset.
  logic [2:0]          flash_n_q;       // Half periods done.
  logic [31:0]         flash_cnt_q;     // Half period timer.
  logic                lamp_q;          // Lamp level during flash.
  logic                any_key;         // Any non-reset press.
  logic                flash_done;      // Last half period ended.

  // ---------------------------------------------------------------
  // Button conditioning
  // ---------------------------------------------------------------
  fpm_debounce #(
    .N   (5),
    .CYC (DEBOUNCE)
  ) u_deb (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .btn_raw ({btn_up, btn_down, btn_side, btn_enter_exit, btn_reset}),
    .press   (key_vec)
  );
  assign key     = key_vec;
  assign any_key = key.up | key.down | key.side | key.enter_exit;

  // Wraps a channel-or-off switcher value through 0..16.
  function automatic logic [4:0] sw_step(input logic [4:0] v, input logic up);
    if (up) sw_step = (v == 5'h10) ? 5'h00 : v + 5'h01;
    else    sw_step = (v == 5'h00) ? 5'h10 : v - 5'h01;
  endfunction : sw_step

  // ---------------------------------------------------------------
  // Lamp flash sequencer
  // ---------------------------------------------------------------
  // Six half periods give three full flashes; shared by reset and lamp test.
  assign flash_done = flashing_q && (flash_cnt_q == FLASH - 1)
                      && (flash_n_q == 3'(2 * FLASH_COUNT - 1));
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flashing_q   <= 1'b1;             // Power-on counts as a reset.
      from_reset_q <= 1'b1;
      flash_n_q    <= 3'h0;
      flash_cnt_q  <= '0;
      lamp_q       <= 1'b1;
    end else if (key.reset_btn) begin
      flashing_q   <= 1'b1;             // Reset press restarts the flash.
      from_reset_q <= 1'b1;
      flash_n_q    <= 3'h0;
      flash_cnt_q  <= '0;
      lamp_q       <= 1'b1;
    end else if (!flashing_q && scr_q == FPM_SCR_MAIN && key.enter_exit
                 && row_q == 3'h1 && col_q == 2'h0) begin
      flashing_q   <= 1'b1;             // Lamp test from the menu.
      from_reset_q <= 1'b0;
      flash_n_q    <= 3'h0;
      flash_cnt_q  <= '0;
      lamp_q       <= 1'b1;
    end else if (flashing_q) begin
      if (flash_cnt_q == FLASH - 1) begin
        flash_cnt_q <= '0;
        lamp_q      <= ~lamp_q;
        if (flash_done) begin
          flashing_q <= 1'b0;
          lamp_q     <= 1'b0;
        end else begin
          flash_n_q <= flash_n_q + 3'h1;
        end
      end else begin
        flash_cnt_q <= flash_cnt_q + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Screen and cursor state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scr_q <= FPM_SCR_INIT;
      top_q <= 3'h0;
      row_q <= 3'h0;
      col_q <= 2'h0;
      fld_q <= 1'b0;
      ch_q  <= 4'h0;
    end else if (key.reset_btn) begin
      scr_q <= FPM_SCR_INIT;
      top_q <= 3'h0;
      row_q <= 3'h0;
      col_q <= 2'h0;
      fld_q <= 1'b0;
      ch_q  <= 4'h0;
    end else begin
      case (scr_q)
        FPM_SCR_INIT: begin
          if (!flashing_q && any_key) begin
            scr_q <= FPM_SCR_MAIN;      // First press shows the menu.
            top_q <= 3'h0;
            row_q <= 3'h0;
            col_q <= 2'h0;              // Cursor on the gain option.
          end
        end
        FPM_SCR_MAIN: begin
          if (key.down && row_q < 3'(MENU_ROWS - 1)) begin
            row_q <= row_q + 3'h1;      // Arrow moves the cursor down.
            col_q <= 2'h0;
            // Every down press scrolls until the last row sits on the bottom line.
            top_q <= (row_q < 3'(MENU_ROWS - 2)) ? row_q + 3'h1
                                                 : 3'(MENU_ROWS - 2);
          end else if (key.up && row_q != 3'h0) begin
            row_q <= row_q - 3'h1;
            col_q <= 2'h0;
            if (row_q == top_q) top_q <= row_q - 3'h1;
          end else if (key.side) begin
            col_q <= (col_q == fpm_row_len(row_q) - 2'h1) ? 2'h0 : col_q + 2'h1;
          end else if (key.enter_exit && row_q == 3'h0) begin
            fld_q <= 1'b0;              // Submenus open on the first field.
            case (col_q)
              2'h0:    scr_q <= FPM_SCR_GAIN;
              2'h1:    scr_q <= FPM_SCR_MUX;
              2'h2:    scr_q <= FPM_SCR_STAT;
              default: scr_q <= FPM_SCR_MAIN;
            endcase
          end else if (key.enter_exit && row_q == 3'h1 && col_q == 2'h0) begin
            scr_q <= FPM_SCR_LEDS;
          end
        end
        FPM_SCR_GAIN, FPM_SCR_MUX, FPM_SCR_STAT: begin
          if (key.enter_exit) begin
            scr_q <= FPM_SCR_MAIN;      // Leave back to the option menu.
          end else if (key.side && scr_q != FPM_SCR_STAT) begin
            fld_q <= ~fld_q;            // Toggle field either way.
          end else if ((key.up || key.down) && (scr_q == FPM_SCR_STAT || !fld_q)
                       && scr_q != FPM_SCR_MUX) begin
            ch_q <= key.up ? ch_q + 4'h1 : ch_q - 4'h1; // Wraps 16 to 01.
          end
        end
        FPM_SCR_LEDS: begin
          if (flash_done) scr_q <= FPM_SCR_MAIN; // Menu after flashing.
        end
        default: scr_q <= FPM_SCR_INIT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Channel gains
  // ---------------------------------------------------------------
  // A gain change drives the channel the same cycle the display updates.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CH; i++) gain_q[i] <= GAIN_X1;
    end else if (key.reset_btn) begin
      for (int i = 0; i < NUM_CH; i++) gain_q[i] <= GAIN_X1;
    end else if (scr_q == FPM_SCR_GAIN && fld_q && (key.up || key.down)) begin
      case (gain_q[ch_q])                // Three steps, wrapping.
        GAIN_X1:  gain_q[ch_q] <= key.up ? GAIN_X10 : GAIN_X100;
        GAIN_X10: gain_q[ch_q] <= key.up ? GAIN_X100 : GAIN_X1;
        default:  gain_q[ch_q] <= key.up ? GAIN_X1 : GAIN_X10;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Switchers
  // ---------------------------------------------------------------
  // Value zero routes nothing; 1 to 16 route that channel.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sw1_q <= SW_NONE;
      sw2_q <= SW_NONE;
    end else if (key.reset_btn) begin
      sw1_q <= SW_NONE;
      sw2_q <= SW_NONE;
    end else if (scr_q == FPM_SCR_MUX && (key.up || key.down)) begin
      if (!fld_q) sw1_q <= sw_step(sw1_q, key.up);
      else        sw2_q <= sw_step(sw2_q, key.up);
    end
  end

  // ---------------------------------------------------------------
  // Overload latch
  // ---------------------------------------------------------------
  // A live overload always sets the bit, so it wins over the read clear.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ovl_latch_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ovld_in[i])
          ovl_latch_q[i] <= 1'b1;
        else if (scr_q == FPM_SCR_STAT && ch_q == 4'(i) && (key.up || key.down
                 || key.enter_exit))
          ovl_latch_q[i] <= 1'b0;       // Cleared when the reader moves on.
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      disp                 <= '0;
      gain_sel             <= '0;
      switcher_one_channel <= SW_NONE;
      switcher_two_channel <= SW_NONE;
      autorange_en         <= 1'b0;
      cal_en               <= 1'b0;
      integ_en             <= 1'b0;
      filter_en            <= 1'b0;
      ovld_thresh_v        <= OVLD_RST_V;
      reset_lamp           <= 1'b0;
      panel_lamps_on       <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) gain_sel[2*i +: 2] <= gain_q[i];
      switcher_one_channel <= sw1_q;
      switcher_two_channel <= sw2_q;
      autorange_en         <= 1'b0;
      cal_en               <= 1'b0;
      integ_en             <= 1'b0;
      filter_en            <= 1'b0;
      ovld_thresh_v        <= OVLD_RST_V;
      reset_lamp           <= !(flashing_q && from_reset_q); // On once init is done.
      panel_lamps_on       <= flashing_q & lamp_q;
      disp.screen          <= scr_q;
      disp.top_row         <= top_q;
      disp.cur_row         <= row_q;
      disp.cur_col         <= col_q;
      disp.rack_number_field <= RACK_RST;
      disp.channel         <= {1'b0, ch_q} + 5'h01;
      disp.gain            <= gain_q[ch_q];
      disp.sub_field       <= fld_q;
      disp.switcher_one_channel <= sw1_q;
      disp.switcher_two_channel <= sw2_q;
      disp.fault_flag      <= fault_in[ch_q];     // One means fault.
      disp.ovld_flag       <= ovl_latch_q[ch_q];
      disp.test_on         <= (scr_q == FPM_SCR_LEDS);
    end
  end
endmodule : fpm_menu
`default_nettype wire

// file: sim/fpm_menu_asserts.sv
// Concurrent checks on the front panel menu controller ports.
`timescale 1ns/1ps
`default_nettype none
module fpm_menu_asserts
  import fpm_pkg::*;
#(
  parameter int unsigned DEBOUNCE = 4, // Settle time in cycles.
  parameter int unsigned FLASH    = 8  // Lamp half period in cycles.
) (
  input wire logic                        clk_sys,
  input wire logic                        nrst,
  input wire logic                        btn_up,
  input wire logic                        btn_down,
  input wire logic                        btn_side,
  input wire logic                        btn_enter_exit,
  input wire logic                        btn_reset,
  input wire logic [fpm_pkg::NUM_CH-1:0]  fault_in,
  input wire logic [fpm_pkg::NUM_CH-1:0]  ovld_in,
  input wire fpm_pkg::fpm_disp_s          disp,
  input wire logic [2*fpm_pkg::NUM_CH-1:0] gain_sel,
  input wire logic [4:0]                  switcher_one_channel,
  input wire logic [4:0]                  switcher_two_channel,
  input wire logic                        autorange_en,
  input wire logic                        cal_en,
  input wire logic                        integ_en,
  input wire logic                        filter_en,
  input wire logic [3:0]                  ovld_thresh_v,
  input wire logic                        reset_lamp,
  input wire logic                        panel_lamps_on
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic [3:0] idx;      // Bit index of the shown channel; 16 maps to 15.
  logic       bad_gain; // Some channel holds the unused gain code.
  assign idx = disp.channel[3:0] - 4'h1;
  // Scan every gain slice, since a stray code would drive no real gain.
  always_comb begin
    bad_gain = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (gain_sel[2*i +: 2] == 2'h3) begin
        bad_gain = 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_off; !(autorange_en | cal_en | integ_en | filter_en); endproperty
  a_off: assert property (p_off) else $error("Feature enable raised.");
  property p_thr; ovld_thresh_v == 4'hA; endproperty
  a_thr: assert property (p_thr) else $error("Threshold not ten volts.");
  property p_init; !reset_lamp [*2] |-> disp.screen == 3'h0; endproperty
  a_init: assert property (p_init) else $error("Menu shown during flash.");
  property p_rst;
    $rose(reset_lamp) |-> gain_sel == '0 && switcher_one_channel == 5'h00
      && switcher_two_channel == 5'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("Defaults missing at lamp on.");
  property p_code; !bad_gain; endproperty
  a_code: assert property (p_code) else $error("Illegal gain code.");
  property p_gsrc; $changed(gain_sel) |-> $past(disp.screen) == 3'h2 || !reset_lamp; endproperty
  a_gsrc: assert property (p_gsrc) else $error("Gain changed outside submenu.");
  property p_ssrc;
    $changed({switcher_one_channel, switcher_two_channel})
      |-> $past(disp.screen) == 3'h3 || !reset_lamp;
  endproperty
  a_ssrc: assert property (p_ssrc) else $error("Switcher changed outside submenu.");
  property p_flt;
    disp.screen == 3'h4 && $past(disp.screen) == 3'h4 && $stable(fault_in)
      && $stable(disp.channel) |-> disp.fault_flag == fault_in[idx];
  endproperty
  a_flt: assert property (p_flt) else $error("Fault flag wrong.");
  property p_ovl; disp.screen == 3'h4 && ovld_in[idx] |-> ##[1:2] disp.ovld_flag; endproperty
  a_ovl: assert property (p_ovl) else $error("Overload flag not set.");
  property p_test; disp.screen == 3'h5 |-> disp.test_on; endproperty
  a_test: assert property (p_test) else $error("Lamp test not shown on.");
endmodule : fpm_menu_asserts
bind fpm_menu fpm_menu_asserts #(.DEBOUNCE(DEBOUNCE), .FLASH(FLASH)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .btn_up(btn_up), .btn_down(btn_down),
  .btn_side(btn_side), .btn_enter_exit(btn_enter_exit), .btn_reset(btn_reset),
  .fault_in(fault_in), .ovld_in(ovld_in), .disp(disp), .gain_sel(gain_sel),
  .switcher_one_channel(switcher_one_channel), .switcher_two_channel(switcher_two_channel),
  .autorange_en(autorange_en), .cal_en(cal_en), .integ_en(integ_en), .filter_en(filter_en),
  .ovld_thresh_v(ovld_thresh_v), .reset_lamp(reset_lamp), .panel_lamps_on(panel_lamps_on));
`default_nettype wire

// file: sim/fpm_operator.sv
// Operator model that presses the five front panel buttons.
`timescale 1ns/1ps
`default_nettype none
module fpm_operator #(
  parameter int unsigned DEBOUNCE = 4 // Settle time of the controller.
) (
  input  wire logic  clk_sys,
  output var logic [4:0] btn // Raw levels {up, down, side, enter_exit, reset}.
);
  initial btn = 5'h00;
  // One button at a time; a short hold models contact bounce.
  // The release is held long enough for the next press to count.
  task automatic press(input int k, input int hold);
    btn[k] <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    btn[k] <= 1'b0;
    repeat (DEBOUNCE + 4) @(posedge clk_sys);
  endtask : press
endmodule : fpm_operator
`default_nettype wire

// file: sim/fpm_menu_tb_top.sv
// Self-checking bench for the front panel menu controller.
`timescale 1ns/1ps
`default_nettype none
module fpm_menu_tb_top;
  import fpm_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int DEB = 4; // Short settle time keeps the run brief.
  localparam int FL  = 8; // Short lamp half period, same reason.
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] btn; // Raw buttons {up, down, side, enter_exit, reset}.
  logic [NUM_CH-1:0] fault_in = '0;
  logic [NUM_CH-1:0] ovld_in = '0;
  fpm_disp_s disp;
  logic [31:0] gain_sel, e_gs;
  logic [4:0] sw1, sw2, e_ch, e_sw1, e_sw2, e_tog;
  logic [4:0] tog = 5'h00; // Lamp toggles seen since time zero.
  logic pl_q = 1'b0;
  logic ar, ce, ie, fe, reset_lamp, panel_lamps_on, e_fld, e_flt, e_ov, e_lamp;
  logic [3:0] thr;
  logic [2:0] e_scr, e_top, e_row;
  logic [1:0] e_col;
  logic [NUM_CH-1:0] f;
  logic [155:0] nq[$]; // Notes of {mask, expected}.
  logic [77:0] m, e;
  int fails = 0;
  int n_tests = 0;
  int gi;
  event chk;
  always #12.5 clk_sys = ~clk_sys;
  fpm_operator #(.DEBOUNCE(DEB)) op (.clk_sys(clk_sys), .btn(btn));
  fpm_menu #(.DEBOUNCE(DEB), .FLASH(FL)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .btn_up(btn[4]), .btn_down(btn[3]),
    .btn_side(btn[2]), .btn_enter_exit(btn[1]), .btn_reset(btn[0]),
    .fault_in(fault_in), .ovld_in(ovld_in), .disp(disp), .gain_sel(gain_sel),
    .switcher_one_channel(sw1), .switcher_two_channel(sw2), .autorange_en(ar),
    .cal_en(ce), .integ_en(ie), .filter_en(fe), .ovld_thresh_v(thr),
    .reset_lamp(reset_lamp), .panel_lamps_on(panel_lamps_on));
  // ---------------------------------------------------------------
  // Result vectors and helpers
  // ---------------------------------------------------------------
  function automatic logic [77:0] act();
    return {disp.screen, disp.top_row, disp.cur_row, disp.cur_col, disp.channel, disp.gain,
            disp.sub_field, sw1, sw2, disp.fault_flag, disp.ovld_flag, disp.test_on,
            gain_sel, reset_lamp, tog, ar, ce, ie, fe, thr};
  endfunction : act
  function automatic logic [77:0] ev();
    return {e_scr, e_top, e_row, e_col, e_ch, e_gs[2*(int'(e_ch)-1) +: 2], e_fld, e_sw1,
            e_sw2, e_flt, e_ov, 1'b0, e_gs, e_lamp, e_tog, 8'h0A};
  endfunction : ev
  // Fields that a screen does not show are masked out of the compare.
  function automatic logic [77:0] msk(input logic [2:0] s);
    logic mn;
    logic gn;
    logic st;
    mn = (s == 3'h1);
    gn = (s == 3'h2);
    st = (s == 3'h4);
    return {3'h7, {8{mn}}, {5{gn | st}}, {3{gn}}, 10'h3FF, {2{st}}, 1'b1, 32'hFFFF_FFFF,
            1'b1, 5'h1F, 8'hFF};
  endfunction : msk
  task automatic note();
    nq.push_back({msk(e_scr), ev()});
    -> chk;
  endtask : note
  task automatic step(input int k, input int h = DEB + 4);
    @(posedge clk_sys);
    op.press(k, h);
    note();
  endtask : step
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // Count lamp toggles; a flash sequence should add exactly six.
  always @(posedge clk_sys) begin
    if (nrst && panel_lamps_on !== pl_q) begin
      tog <= tog + 5'h01;
    end
    pl_q <= panel_lamps_on;
  end
  // Take the oldest note whenever a result is announced.
  always begin
    @(chk);
    {m, e} = nq.pop_front();
    n_tests++;
    if ((act() & m) !== (e & m)) begin
      fails++;
      $display("FAIL %0t: got %h want %h", $time, act() & m, e & m);
    end
  end
  // Watchdog, far beyond the fewer than 1500 cycles the sequence needs.
  initial begin
    #(25 * 20000);
    fails++;
    results();
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h63b4d184));
    {e_scr, e_top, e_row, e_col, e_fld, e_sw1, e_sw2, e_flt, e_ov, e_gs} = '0;
    e_ch = 5'h01;
    e_lamp = 1'b1;
    e_tog = 5'h06;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 300 && reset_lamp !== 1'b1; i++) @(posedge clk_sys);
    note();
    e_scr = 3'h1;
    step(2);
    e_row = 3'h1;
    e_top = 3'h1;
    step(3);
    @(posedge clk_sys);
    op.press(1, DEB + 4);
    for (int i = 0; i < 300 && disp.screen !== 3'h1; i++) @(posedge clk_sys);
    e_tog = 5'h0C;
    note();
    e_row = 3'h0;
    e_top = 3'h0;
    step(4);
    for (int i = 1; i < 3; i++) begin
      e_col = 2'(i);
      step(2);
    end
    f = NUM_CH'($urandom());
    fault_in <= f;
    e_scr = 3'h4;
    e_flt = f[0];
    step(1);
    ovld_in <= 16'h0003;
    repeat (3) @(posedge clk_sys);
    ovld_in <= 16'h0000;
    repeat (3) @(posedge clk_sys);
    e_ov = 1'b1;
    note();
    e_ch = 5'h02;
    e_flt = f[1];
    step(4);
    e_ch = 5'h01;
    e_flt = f[0];
    e_ov = 1'b0;
    step(3);
    e_scr = 3'h1;
    step(1);
    e_col = 2'h0;
    step(2);
    e_scr = 3'h2;
    step(1);
    repeat ($urandom_range(20, 1)) begin
      e_ch = (e_ch == 5'h10) ? 5'h01 : e_ch + 5'h01;
      step(4);
    end
    e_ch = (e_ch == 5'h01) ? 5'h10 : e_ch - 5'h01;
    step(3);
    step(4, 2);
    e_fld = 1'b1;
    step(2);
    gi = 2 * (int'(e_ch) - 1);
    repeat (4) begin
      e_gs[gi +: 2] = (e_gs[gi +: 2] == 2'h2) ? 2'h0 : e_gs[gi +: 2] + 2'h1;
      step(4);
    end
    e_fld = 1'b0;
    step(2);
    e_scr = 3'h1;
    step(1);
    e_col = 2'h1;
    step(2);
    e_scr = 3'h3;
    step(1);
    e_sw1 = 5'h01;
    step(4);
    step(2);
    repeat (18) begin
      e_sw2 = (e_sw2 == 5'h10) ? 5'h00 : e_sw2 + 5'h01;
      step(4);
    end
    e_scr = 3'h1;
    step(1);
    e_col = 2'h0;
    for (int i = 1; i < 6; i++) begin
      e_row = (i < 5) ? 3'(i) : 3'h4;
      e_top = (e_row > 3'h3) ? 3'h3 : e_row;
      step(3);
    end
    @(posedge clk_sys);
    op.press(0, DEB + 4);
    for (int i = 0; i < 300 && reset_lamp !== 1'b1; i++) @(posedge clk_sys);
    {e_scr, e_top, e_row, e_col, e_sw1, e_sw2, e_gs} = '0;
    e_tog = 5'h12;
    note();
    @(posedge clk_sys);
    results();
  end
endmodule : fpm_menu_tb_top
`default_nettype wire
